// [design/dacc_pkg.sv]
// Purpose: shared constants and types for the converter control block
// Assumes: 10 MHz peripheral clock, byte-wide register port
// Notes: register offsets are byte addresses on the plain port
package dacc_pkg;
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] DATA_ADDR = 8'h01;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int CTRL_RUN_BIT = 7;
  localparam int CTRL_PIN_BIT = 6;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [7:0] CTRL_MASK = 8'hC1;
  localparam int CODE_WIDTH = 8;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int SAMPLE_RATE_SPS = 350_000;
  // shortest conversion slot, rounded up to whole cycles
  localparam int CONV_CYCLES = (CLK_HZ + SAMPLE_RATE_SPS - 1)
                               / SAMPLE_RATE_SPS;
  localparam int STARTUP_NS = 10_000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  typedef struct packed {
    logic keep_running_in_sleep;
    logic pin_buffer_on;
    logic enable;
  } dacc_ctrl_t;

  typedef struct packed {
    logic core_on;
    logic buffer_on;
    logic pin_drive;
    logic internal_valid;
  } dacc_analog_t;

  typedef enum logic [1:0] {
    DACC_SLEEP_NONE,
    DACC_SLEEP_STANDBY,
    DACC_SLEEP_POWERDOWN
  } dacc_sleep_t;
endpackage : dacc_pkg

// [design/dacc_timer.sv]
// Purpose: loadable down counter marking the end of a timed interval
// Assumes: load and count values below 2**CNT_W
// Notes: busy stays high while the count is above zero
`timescale 1ns/1ps
module dacc_timer
  import dacc_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_value,
  input wire logic hold,
  output logic busy,
  output logic done
);
  logic [CNT_W-1:0] count;
  wire logic last = (count == 8'h01);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count <= 8'h00;
    end else if (load) begin
      count <= load_value;
    end else if (busy && !hold) begin
      count <= count - 8'h01;
    end
  end

  assign busy = (count != 8'h00);
  assign done = last && !load && !hold;
endmodule : dacc_timer

// [design/dacc_core.sv]
// Purpose: control logic of an 8-bit voltage-output converter
// Assumes: register port strobes one cycle long, never both at once
// Notes: analog core, reference select and pin mux live outside
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps
module dacc_core
  import dacc_pkg::*;
#(
  parameter bit INSTANCE_ZERO = 1'b1
)
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire dacc_sleep_t sleep_mode,
  input wire logic clk_per_avail,
  input wire logic debug_halt,
  output logic [CODE_WIDTH-1:0] analog_code,
  output logic analog_load,
  output dacc_analog_t analog,
  output logic converting
);
  typedef enum logic [1:0] {
    DACC_OFF,
    DACC_STARTUP,
    DACC_READY,
    DACC_CONVERT
  } dacc_state_t;

  dacc_state_t state;
  dacc_state_t next_state;
  dacc_ctrl_t ctrl;
  logic [CODE_WIDTH-1:0] code;
  logic pending;
  logic next_pending;

  // register decode
  wire logic wr_ctrl = wr && (addr == CTRL_ADDR);
  wire logic wr_data = wr && (addr == DATA_ADDR);
  wire logic rd_ctrl = rd && (addr == CTRL_ADDR);
  wire logic rd_data = rd && (addr == DATA_ADDR);
  wire logic en_rise = wr_ctrl && wdata[CTRL_EN_BIT] && !ctrl.enable;

  // sleep gating; debug_halt intentionally takes no part
  wire logic in_standby = (sleep_mode == DACC_SLEEP_STANDBY);
  wire logic in_pdown = (sleep_mode == DACC_SLEEP_POWERDOWN);
  wire logic keep_ok = ctrl.keep_running_in_sleep && clk_per_avail;
  wire logic run_ok = !in_pdown &&
                      !(in_standby && !keep_ok);
  wire logic powered = ctrl.enable && run_ok;

  logic tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic tmr_busy;
  logic tmr_done;

  dacc_timer u_timer (
    .clock(clock),
    .arst_n(arst_n),
    .load(tmr_load),
    .load_value(tmr_value),
    .hold(1'b0),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // registers run on every edge; debug_halt is left unread on purpose
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= '0;
      code <= DATA_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl.keep_running_in_sleep <= wdata[CTRL_RUN_BIT];
        ctrl.pin_buffer_on <= wdata[CTRL_PIN_BIT];
        ctrl.enable <= wdata[CTRL_EN_BIT];
      end
      if (wr_data) begin
        code <= wdata;
      end
    end
  end

  // read data one cycle after the strobe, reserved bits zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (rd_ctrl) begin
      rdata <= {ctrl.keep_running_in_sleep, ctrl.pin_buffer_on,
                5'h00, ctrl.enable};
    end else if (rd_data) begin
      rdata <= code;
    end else begin
      rdata <= 8'h00;
    end
  end

  // a start request is remembered until the core can take it
  wire logic start_req = (wr_data && (ctrl.enable || en_rise))
                         || en_rise;

  always_comb begin
    next_state = state;
    next_pending = pending || start_req;
    tmr_load = 1'b0;
    tmr_value = 8'h00;
    unique case (state)
      DACC_OFF: begin
        if (powered) begin
          // core needs settling time after power-up before converting
          next_state = DACC_STARTUP;
          tmr_load = 1'b1;
          tmr_value = CNT_W'(STARTUP_CYCLES);
        end
      end
      DACC_STARTUP: begin
        if (!powered) begin
          next_state = DACC_OFF;
        end else if (tmr_done) begin
          next_state = DACC_READY;
        end
      end
      DACC_READY: begin
        if (!powered) begin
          next_state = DACC_OFF;
        end else if (next_pending) begin
          next_state = DACC_CONVERT;
          next_pending = 1'b0;
          tmr_load = 1'b1;
          tmr_value = CNT_W'(CONV_CYCLES);
        end
      end
      DACC_CONVERT: begin
        if (!powered) begin
          next_state = DACC_OFF;
        end else if (tmr_done) begin
          next_state = DACC_READY;
        end
      end
    endcase
    // disabled: no conversion pending after a plain data write
    if (!ctrl.enable && !en_rise) begin
      next_pending = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= DACC_OFF;
      pending <= 1'b0;
    end else begin
      state <= next_state;
      pending <= next_pending;
    end
  end

  // code latched into the string at conversion start; a write in the
  // starting cycle wins, a newer write during the slot stays pending
  wire logic conv_start = (state == DACC_READY)
                          && (next_state == DACC_CONVERT);
  wire logic [CODE_WIDTH-1:0] latest_code = wr_data ? wdata : code;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      analog_code <= DATA_RESET;
      analog_load <= 1'b0;
    end else begin
      analog_load <= conv_start;
      if (conv_start) begin
        analog_code <= latest_code;
      end
    end
  end

  wire logic core_on = powered && (state != DACC_OFF);
  wire logic buf_on = core_on && ctrl.pin_buffer_on
                      && INSTANCE_ZERO;
  // the pin drive follows the buffer; the internal path needs only the core
  assign analog = {core_on, buf_on, buf_on, core_on};
  assign converting = (state == DACC_CONVERT);

  // checks
  property p_data_start;
    @(posedge clock) disable iff (!arst_n)
      (wr_data && ctrl.enable && state == DACC_READY && powered)
      |=> state == DACC_CONVERT;
  endproperty
  a_data_start: assert property (p_data_start)
    else $error("no start");

  property p_no_start_off;
    @(posedge clock) disable iff (!arst_n)
      (wr_data && !ctrl.enable) |=> !pending && !analog_load;
  endproperty
  a_no_start_off: assert property (p_no_start_off)
    else $error("bad start");

  property p_enable_start;
    @(posedge clock) disable iff (!arst_n)
      (en_rise && run_ok) |-> ##[1:110] analog_load;
  endproperty
  a_enable_start: assert property (p_enable_start)
    else $error("no run");

  property p_enable_follow;
    @(posedge clock) disable iff (!arst_n)
      wr_ctrl |=> ctrl.enable == $past(wdata[CTRL_EN_BIT]);
  endproperty
  a_enable_follow: assert property (p_enable_follow)
    else $error("en");

  property p_pin_only;
    @(posedge clock) disable iff (!arst_n)
      analog.pin_drive |-> ctrl.pin_buffer_on && ctrl.enable;
  endproperty
  a_pin_only: assert property (p_pin_only)
    else $error("pin");

  property p_internal;
    @(posedge clock) disable iff (!arst_n)
      ($rose(ctrl.enable) && run_ok) |=> analog.internal_valid || !powered;
  endproperty
  a_internal: assert property (p_internal)
    else $error("no internal output");

  property p_keep_run;
    @(posedge clock) disable iff (!arst_n)
      (in_standby && powered && state != DACC_OFF) |=> state != DACC_OFF;
  endproperty
  a_keep_run: assert property (p_keep_run)
    else $error("stopped in standby");

  property p_pdown;
    @(posedge clock) disable iff (!arst_n)
      in_pdown |-> !analog.core_on && !analog.buffer_on;
  endproperty
  a_pdown: assert property (p_pdown)
    else $error("pdown on");

  property p_standby_off;
    @(posedge clock) disable iff (!arst_n)
      (in_standby && !ctrl.keep_running_in_sleep) |-> !analog.core_on;
  endproperty
  a_standby_off: assert property (p_standby_off)
    else $error("sb");

  property p_sleep_off;
    @(posedge clock) disable iff (!arst_n)
      (in_standby && !keep_ok)
      |-> !analog.core_on && !analog.buffer_on ##1 state == DACC_OFF;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("standby power left on");

  property p_wake;
    @(posedge clock) disable iff (!arst_n)
      $fell(in_standby) && state == DACC_OFF && powered
      |=> state == DACC_STARTUP [*8];
  endproperty
  a_wake: assert property (p_wake)
    else $error("startup");

  // cycles since the last load, saturating; guards the slot spacing
  logic [CNT_W-1:0] since_load;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      since_load <= 8'hFF;
    end else if (analog_load) begin
      since_load <= 8'h00;
    end else if (since_load != 8'hFF) begin
      since_load <= since_load + 8'h01;
    end
  end

  property p_slot;
    @(posedge clock) disable iff (!arst_n)
      analog_load |-> since_load >= CNT_W'(CONV_CYCLES - 1);
  endproperty
  a_slot: assert property (p_slot)
    else $error("slots too close");

  property p_read_data;
    @(posedge clock) disable iff (!arst_n)
      rd_data |=> rdata == $past(code);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("data read");

  property p_ctrl_rsvd;
    @(posedge clock) disable iff (!arst_n)
      rd_ctrl |=> (rdata & ~CTRL_MASK) == 8'h00;
  endproperty
  a_ctrl_rsvd: assert property (p_ctrl_rsvd)
    else $error("reserved bits set");

  property p_latest;
    @(posedge clock) disable iff (!arst_n)
      analog_load |-> analog_code == code;
  endproperty
  a_latest: assert property (p_latest)
    else $error("stale");

  c_conv: cover property (@(posedge clock) analog_load);
  c_wake: cover property (@(posedge clock) $fell(in_standby) && powered);
  c_pin: cover property (@(posedge clock) analog.pin_drive);
  c_pdown: cover property (@(posedge clock) in_pdown && ctrl.enable);
endmodule : dacc_core

// [tb/testbench.sv]
// Purpose: self-checking bench for the converter control block
// Assumes: 10 MHz clock, async active-low reset, assertions live in design
// Notes: driver queues expected reads and loads, a monitor checks them
`timescale 1ns/1ps
module testbench;
  import dacc_pkg::*;
  logic clock;
  logic arst_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  dacc_sleep_t sleep_mode;
  logic clk_per_avail;
  logic debug_halt;
  logic [CODE_WIDTH-1:0] analog_code;
  logic analog_load;
  dacc_analog_t analog;
  logic converting;
  logic rd_seen;
  logic [7:0] rq[$];
  logic [7:0] lq[$];
  int num_errors;
  int cmp_count;
  int cyc;
  int last_load;
  int seed;
  logic [7:0] code;
  logic [7:0] code2;
  logic spaced;

  dacc_core dut (.clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sleep_mode(sleep_mode),
    .clk_per_avail(clk_per_avail), .debug_halt(debug_halt),
    .analog_code(analog_code), .analog_load(analog_load), .analog(analog),
    .converting(converting));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic stop_test;
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic check(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : check

  // a hang is cut short well past the longest expected run
  always @(posedge clock) begin
    rd_seen <= rd;
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      num_errors++;
      stop_test();
    end
  end

  always @(negedge clock) begin
    if (rd_seen === 1'b1) begin
      if (rq.size() == 0) check("read_unexpected", 8'h00, 8'hFF);
      else check("rdata", rq.pop_front(), rdata);
    end
    if (analog_load === 1'b1) begin
      spaced = (cyc - last_load) >= CONV_CYCLES;
      check("load_spacing", 8'h01, {7'h00, spaced});
      check("converting", 8'h01, {7'h00, converting});
      last_load = cyc;
      if (lq.size() == 0) check("load_unexpected", 8'h00, 8'hFF);
      else check("analog_code", lq.pop_front(), analog_code);
    end
  end

  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(logic [7:0] a, logic [7:0] e);
    rq.push_back(e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
  endtask : rd_reg

  task automatic start_code;
    code = 8'($random(seed));
    lq.push_back(code);
    wr_reg(DATA_ADDR, code);
  endtask : start_code

  // the pad lets the slot end so the next write starts a fresh conversion
  task automatic wait_loads;
    int n;
    n = 0;
    while (lq.size() != 0 && n < 400) begin
      @(posedge clock);
      n++;
    end
    check("load_pending", 8'h00, 8'(lq.size()));
    repeat (40) @(posedge clock);
  endtask : wait_loads

  task automatic chk_an(logic [3:0] e, logic [3:0] m);
    @(negedge clock);
    check("analog", {4'h0, e & m}, {4'h0, analog & m});
  endtask : chk_an

  task automatic set_sleep(dacc_sleep_t s, logic k);
    @(posedge clock);
    sleep_mode <= s;
    clk_per_avail <= k;
  endtask : set_sleep

  initial begin
    seed = 99046;
    last_load = -1000;
    arst_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    sleep_mode = DACC_SLEEP_NONE;
    clk_per_avail = 1'b1;
    debug_halt = 1'b0;
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    chk_an(4'h0, 4'hF);
    rd_reg(CTRL_ADDR, CTRL_RESET);
    rd_reg(DATA_ADDR, DATA_RESET);
    rd_reg(8'h02, 8'h00);
    code = 8'($random(seed));
    wr_reg(DATA_ADDR, code);
    wr_reg(8'h05, 8'hAA);
    rd_reg(DATA_ADDR, code);
    repeat (150) @(posedge clock);
    lq.push_back(code);
    wr_reg(CTRL_ADDR, 8'hFF);
    rd_reg(CTRL_ADDR, CTRL_MASK);
    wait_loads();
    chk_an(4'hF, 4'hF);
    for (int i = 0; i < 4; i++) begin
      start_code();
      wait_loads();
    end
    start_code();
    while (lq.size() != 0) @(posedge clock);
    code2 = 8'($random(seed));
    wr_reg(DATA_ADDR, ~code2);
    lq.push_back(code2);
    wr_reg(DATA_ADDR, code2);
    wait_loads();
    set_sleep(DACC_SLEEP_STANDBY, 1'b1);
    chk_an(4'hF, 4'hC);
    start_code();
    wait_loads();
    set_sleep(DACC_SLEEP_STANDBY, 1'b0);
    chk_an(4'h0, 4'hC);
    set_sleep(DACC_SLEEP_NONE, 1'b1);
    repeat (120) @(posedge clock);
    wr_reg(CTRL_ADDR, 8'h41);
    set_sleep(DACC_SLEEP_STANDBY, 1'b1);
    chk_an(4'h0, 4'hC);
    set_sleep(DACC_SLEEP_NONE, 1'b1);
    // the state leaves OFF one edge after the sleep request drops
    @(posedge clock);
    chk_an(4'hC, 4'hC);
    start_code();
    repeat (STARTUP_CYCLES - 10) @(posedge clock);
    check("startup_wait", 8'h01, 8'(lq.size()));
    wait_loads();
    wr_reg(CTRL_ADDR, 8'hC1);
    set_sleep(DACC_SLEEP_POWERDOWN, 1'b1);
    chk_an(4'h0, 4'hC);
    set_sleep(DACC_SLEEP_NONE, 1'b1);
    repeat (120) @(posedge clock);
    wr_reg(CTRL_ADDR, 8'h01);
    chk_an(4'h9, 4'hF);
    @(posedge clock);
    debug_halt <= 1'b1;
    start_code();
    wait_loads();
    debug_halt <= 1'b0;
    wr_reg(CTRL_ADDR, 8'h00);
    chk_an(4'h0, 4'hF);
    code = 8'($random(seed));
    wr_reg(DATA_ADDR, code);
    rd_reg(DATA_ADDR, code);
    repeat (150) @(posedge clock);
    stop_test();
  end
endmodule : testbench
